// *** common/rcseq_pkg.sv ***
/*
 * rcseq_pkg: constants for the reset cause sequencer.
 * Assumes a 20 MHz system clock; register offsets are byte addresses of
 * the AXI4-Lite slave (printed offsets are not all multiples of four).
 */
package rcseq_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CORE_STATUS  = 8'h03;
    localparam logic [7:0]  IDX_RESET_CAUSE  = 8'h8e;
    localparam logic [11:0] ADDR_CORE_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_RESET_CAUSE = 12'h238;
    localparam logic [11:0] ADDR_CONFIG      = 12'h400;
    localparam logic [11:0] ADDR_SEQ_STATE   = 12'h404;
    localparam logic [11:0] ADDR_PC          = 12'h408;

    // field positions
    localparam int BIT_EXPIRY    = 4;
    localparam int BIT_SLEEP     = 3;
    localparam int BIT_BROWNOUT  = 0;
    localparam int BIT_POWERON   = 1;
    localparam int CFG_BOD_EN    = 0;
    localparam int CFG_POWERUP_DELAY_TIMER_DIS  = 1;
    localparam int CFG_OSC_LSB   = 2;

    // values after reset, and the interrupt wake vector
    localparam logic [7:0]  STATUS_POR     = 8'h18;
    localparam logic [1:0]  CAUSE_POR      = 2'b00;
    localparam logic [1:0]  CAUSE_BOD      = 2'b10;
    localparam logic [12:0] PC_RESET       = 13'h0000;
    localparam logic [12:0] PC_IRQ_VECTOR  = 13'h0004;
    localparam logic [4:0]  CONFIG_RESET   = 5'h01;

    // timing
    localparam int CLK_HZ                 = 20_000_000;
    localparam int POWERUP_DELAY_MS       = 72;
    localparam int POWERUP_DELAY_CYC      = CLK_HZ / 1000 * POWERUP_DELAY_MS;
    localparam int MASTER_CLEAR_N_MIN_NS            = 2000;
    localparam int MASTER_CLEAR_N_MIN_CYC           = (MASTER_CLEAR_N_MIN_NS + 49) / 50;
    localparam int BOD_MIN_NS             = 100_000;
    localparam int BOD_MIN_CYC            = (BOD_MIN_NS + 49) / 50;
    localparam int STARTUP_OSC_PERIODS    = 1024;

    // oscillator modes
    typedef enum logic [2:0] {
        RCSEQ_LP, RCSEQ_XT, RCSEQ_HS, RCSEQ_RC, RCSEQ_EC, RCSEQ_INTERNAL_OSC_MODE
    } rcseq_osc_t;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** rtl/rcseq_top.sv ***
/*
 * rcseq_top: reset cause sequencer with AXI4-Lite register slave.
 * Assumes supply monitor, brown-out comparator, master-clear pin and
 * watchdog arrive asynchronously; the oscillator ticks once per period.
 */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module rcseq_top
    import rcseq_pkg::*;
#(
    parameter int POWERUP_CYC = rcseq_pkg::POWERUP_DELAY_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // analog and pin inputs
    input  wire logic        supply_good,
    input  wire logic        brownout_below,
    input  wire logic        master_clear_n,
    input  wire logic        watchdog_expire,
    input  wire logic        osc_tick,
    // core side
    input  wire logic        core_sleeping,
    input  wire logic        irq_wake,
    input  wire logic        global_irq_enable,
    input  wire logic [12:0] core_pc,
    output logic             core_reset,
    output logic             core_wake,
    output logic [12:0]      pc_load,
    // axi4-lite slave
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    typedef enum logic [2:0] {
        RCSEQ_HOLD, RCSEQ_POWERUP_DELAY_TIMER, RCSEQ_OST, RCSEQ_MCLRW, RCSEQ_RUN, RCSEQ_WAKE
    } rcseq_state_t;

    rcseq_state_t state;
    logic [22:0]  timer;
    logic [10:0]  osc_cnt;
    logic [15:0]  master_clear_n_cnt;
    logic [15:0]  bod_cnt;
    logic [2:0]   s_sup, s_bod, s_master_clear_n, s_wdt, s_osc;
    logic         por_done, bod_trip, master_clear_n_low, wdt_prev, osc_prev;
    logic         bod_event, wdt_event, osc_edge, master_clear_n_event, pending_bod;
    logic [7:0]   core_status;
    logic [1:0]   reset_cause_flags;
    logic [4:0]   config_reg;
    logic         aw_got, w_got;
    logic [11:0]  aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;

    function automatic logic is_crystal(input logic [2:0] m);
        return m == RCSEQ_LP || m == RCSEQ_XT || m == RCSEQ_HS;
    endfunction

    // two-flop synchronisers, third stage for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_sup  <= '0;
            s_bod  <= '0;
            s_master_clear_n <= '0;
            s_wdt  <= '0;
            s_osc  <= '0;
        end else begin
            s_sup  <= {s_sup[1:0], supply_good};
            s_bod  <= {s_bod[1:0], brownout_below};
            s_master_clear_n <= {s_master_clear_n[1:0], master_clear_n};
            s_wdt  <= {s_wdt[1:0], watchdog_expire};
            s_osc  <= {s_osc[1:0], osc_tick};
        end
    end

    assign wdt_event = s_wdt[1] & ~wdt_prev;
    assign osc_edge  = s_osc[1] & ~osc_prev;
    assign bod_event = bod_trip & config_reg[CFG_BOD_EN];
    assign master_clear_n_event = master_clear_n_low;

    // master-clear glitch filter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_clear_n_cnt <= '0;
            master_clear_n_low <= 1'b0;
            wdt_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            wdt_prev <= s_wdt[1];
            osc_prev <= s_osc[1];
            if (s_master_clear_n[1]) begin
                master_clear_n_cnt <= '0;
                master_clear_n_low <= 1'b0;
            end else if (master_clear_n_cnt < 16'(MASTER_CLEAR_N_MIN_CYC)) begin
                master_clear_n_cnt <= master_clear_n_cnt + 16'd1;
            end else begin
                master_clear_n_low <= 1'b1;
            end
        end
    end

    // brown-out duration qualifier
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bod_cnt  <= '0;
            bod_trip <= 1'b0;
        end else if (!s_bod[1]) begin
            bod_cnt  <= '0;
            bod_trip <= 1'b0;
        end else if (bod_cnt < 16'(BOD_MIN_CYC)) begin
            bod_cnt <= bod_cnt + 16'd1;
        end else begin
            bod_trip <= 1'b1;
        end
    end

    // sequencer; aresetn models the power-on pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= RCSEQ_HOLD;
            timer       <= '0;
            osc_cnt     <= '0;
            por_done    <= 1'b0;
            pending_bod <= 1'b0;
            core_reset  <= 1'b1;
            core_wake   <= 1'b0;
            pc_load     <= PC_RESET;
        end else begin
            core_wake <= 1'b0;
            if (bod_event && state != RCSEQ_HOLD) begin
                state       <= RCSEQ_HOLD;
                core_reset  <= 1'b1;
                pending_bod <= 1'b1;
                pc_load     <= PC_RESET;
            end else if (wdt_event && state == RCSEQ_RUN && !core_sleeping) begin
                state      <= RCSEQ_HOLD;
                core_reset <= 1'b1;
                pc_load    <= PC_RESET;
            end else begin
                unique case (state)
                    RCSEQ_HOLD: begin
                        timer   <= '0;
                        osc_cnt <= '0;
                        if (s_sup[1] && !bod_event) begin
                            if (pending_bod && config_reg[CFG_POWERUP_DELAY_TIMER_DIS]) begin
                                state <= RCSEQ_OST;
                            end else if (!config_reg[CFG_POWERUP_DELAY_TIMER_DIS]) begin
                                state <= RCSEQ_POWERUP_DELAY_TIMER;
                            end else begin
                                state <= RCSEQ_OST;
                            end
                        end
                    end
                    RCSEQ_POWERUP_DELAY_TIMER: begin
                        if (!s_sup[1]) begin
                            state <= RCSEQ_HOLD;
                        end else if (timer >= 23'(POWERUP_CYC - 1)) begin
                            state <= RCSEQ_OST;
                        end else begin
                            timer <= timer + 23'd1;
                        end
                    end
                    RCSEQ_OST: begin
                        if (!is_crystal(config_reg[CFG_OSC_LSB +: 3])) begin
                            state <= RCSEQ_MCLRW;
                        end else if (osc_cnt == 11'(STARTUP_OSC_PERIODS)) begin
                            state <= RCSEQ_MCLRW;
                        end else if (osc_edge) begin
                            osc_cnt <= osc_cnt + 11'd1;
                        end
                    end
                    RCSEQ_MCLRW: begin
                        por_done    <= 1'b1;
                        pending_bod <= 1'b0;
                        if (!master_clear_n_event) begin
                            state      <= RCSEQ_RUN;
                            core_reset <= 1'b0;
                        end
                    end
                    RCSEQ_RUN: begin
                        osc_cnt <= '0;
                        if (master_clear_n_event) begin
                            state      <= RCSEQ_MCLRW;
                            core_reset <= 1'b1;
                            pc_load    <= PC_RESET;
                        end else if (core_sleeping && (wdt_event || irq_wake)) begin
                            state <= RCSEQ_WAKE;
                            if (irq_wake && global_irq_enable) begin
                                pc_load <= PC_IRQ_VECTOR;
                            end else begin
                                pc_load <= core_pc + 13'd1;
                            end
                        end
                    end
                    RCSEQ_WAKE: begin
                        if (!is_crystal(config_reg[CFG_OSC_LSB +: 3])
                            || osc_cnt == 11'(STARTUP_OSC_PERIODS)) begin
                            state     <= RCSEQ_RUN;
                            core_wake <= 1'b1;
                        end else if (osc_edge) begin
                            osc_cnt <= osc_cnt + 11'd1;
                        end
                    end
                endcase
            end
        end
    end

    // status and cause flags; software writes lose to hardware events
    logic wr_fire;
    assign wr_fire = aw_got && w_got && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_status       <= STATUS_POR;
            reset_cause_flags <= CAUSE_POR;
        end else begin
            if (wr_fire && aw_addr == ADDR_CORE_STATUS && w_strb[0]) begin
                core_status[2:0] <= w_data[2:0];
            end
            if (wr_fire && aw_addr == ADDR_RESET_CAUSE && w_strb[0]) begin
                reset_cause_flags <= w_data[1:0];
            end
            if (bod_event && state != RCSEQ_HOLD) begin
                reset_cause_flags             <= CAUSE_BOD;
                core_status[BIT_EXPIRY]       <= 1'b1;
                core_status[BIT_SLEEP]        <= 1'b1;
            end else if (wdt_event && state == RCSEQ_RUN && !core_sleeping) begin
                core_status[7:4] <= 4'h0;
            end else if (state == RCSEQ_RUN && master_clear_n_event && core_sleeping) begin
                core_status[BIT_EXPIRY] <= 1'b1;
                core_status[BIT_SLEEP]  <= 1'b0;
            end else if (state == RCSEQ_RUN && core_sleeping && wdt_event) begin
                core_status[BIT_EXPIRY] <= 1'b0;
                core_status[BIT_SLEEP]  <= 1'b0;
            end else if (state == RCSEQ_RUN && core_sleeping && irq_wake) begin
                core_status[BIT_EXPIRY] <= 1'b1;
                core_status[BIT_SLEEP]  <= 1'b0;
            end
        end
    end

    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= '0;
            w_data    <= '0;
            w_strb    <= '0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            config_reg <= CONFIG_RESET;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got    <= 1'b1;
                aw_addr   <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_got    <= 1'b1;
                w_data   <= s_wdata;
                w_strb   <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_bvalid <= 1'b1;
                if (aw_addr == ADDR_CONFIG && w_strb[0]) begin
                    config_reg <= w_data[4:0];
                end
                s_bresp <= (aw_addr == ADDR_CORE_STATUS || aw_addr == ADDR_RESET_CAUSE
                            || aw_addr == ADDR_CONFIG) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                aw_got    <= 1'b0;
                w_got     <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rresp   <= RESP_OKAY;
            unique case (s_araddr)
                ADDR_CORE_STATUS: s_rdata <= {24'h0000_00, core_status};
                ADDR_RESET_CAUSE: s_rdata <= {30'h0000_0000, reset_cause_flags};
                ADDR_CONFIG:      s_rdata <= {27'h0000_000, config_reg};
                ADDR_SEQ_STATE:   s_rdata <= {28'h0000_000, por_done, 3'(state)};
                ADDR_PC:          s_rdata <= {19'h0_0000, pc_load};
                default: begin
                    s_rdata <= '0;
                    s_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // checks
    AST_HOLD_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
        state == RCSEQ_HOLD |=> core_reset) else $error("core released in hold");
    AST_POWERUP_DELAY_TIMER_SUPPLY: assert property (@(posedge aclk) disable iff (!aresetn)
        state == RCSEQ_POWERUP_DELAY_TIMER && !s_sup[1] && !bod_event |=> state == RCSEQ_HOLD)
        else $error("supply loss not restarting delay");
    AST_BOD_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        bod_event && state != RCSEQ_HOLD |=> reset_cause_flags == CAUSE_BOD)
        else $error("brown-out cause not loaded");
    AST_BOD_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
        !config_reg[CFG_BOD_EN] |-> !bod_event) else $error("brown-out while disabled");
    AST_MASTER_CLEAR_N_FILTER: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(master_clear_n_low) |-> $past(master_clear_n_cnt) == 16'(MASTER_CLEAR_N_MIN_CYC))
        else $error("master-clear qualified early");
    AST_WDT_NIBBLE: assert property (@(posedge aclk) disable iff (!aresetn)
        wdt_event && state == RCSEQ_RUN && !core_sleeping && !bod_event
        |=> core_status[7:4] == 4'h0 && core_status[3:0] == $past(core_status[3:0]))
        else $error("watchdog status wrong");
    AST_WAKE_PC: assert property (@(posedge aclk) disable iff (!aresetn)
        state == RCSEQ_RUN && core_sleeping && irq_wake && global_irq_enable
        && !master_clear_n_event && !bod_event && !wdt_event |=> pc_load == PC_IRQ_VECTOR)
        else $error("wake vector wrong");
    AST_RUN_FREE: assert property (@(posedge aclk) disable iff (!aresetn)
        state == RCSEQ_RUN |-> !core_reset) else $error("reset during run");
    COV_RUN: cover property (@(posedge aclk) disable iff (!aresetn) $fell(core_reset));
    COV_BOD: cover property (@(posedge aclk) disable iff (!aresetn) bod_event);
    COV_WAKE: cover property (@(posedge aclk) disable iff (!aresetn) core_wake);
endmodule

// *** test/rcseq_partner.sv ***
/*
 * rcseq_partner: supply monitor, master-clear pin, watchdog and oscillator.
 * Assumes the bench sets request levels; pins follow on the next aclk edge.
 */
`timescale 1ns/1ps
module rcseq_partner (
    // clock
    input  wire logic       aclk,
    // requests: supply dip, below threshold, pin low, watchdog expiry
    input  wire logic [3:0] req,
    // pins toward the device
    output logic            supply_good,
    output logic            brownout_below,
    output logic            master_clear_n,
    output logic            watchdog_expire,
    output logic            osc_tick
);
    logic [1:0] osc_div;

    initial begin
        supply_good     = 1'b1;
        brownout_below  = 1'b0;
        master_clear_n  = 1'b0;
        watchdog_expire = 1'b0;
        osc_div         = 2'h0;
    end

    always @(posedge aclk) begin
        supply_good     <= !req[3];
        brownout_below  <= req[2];
        master_clear_n  <= !req[1];
        watchdog_expire <= req[0];
        osc_div         <= osc_div + 2'h1;
    end

    // oscillator runs free, one period per four aclk
    assign osc_tick = osc_div[1];
endmodule

// *** test/tb_reset_cause_sequencer.sv ***
/*
 * tb_reset_cause_sequencer: bench for rcseq_top over AXI4-Lite.
 * Assumes rcseq_partner drives the pins; power-up delay shortened to 50.
 */
`timescale 1ns/1ps
module tb_reset_cause_sequencer;
    import rcseq_pkg::*;
    localparam int PWR_CYC = 50;
    logic        aclk;
    logic        aresetn;
    logic [3:0]  req;
    logic        supply_good, brownout_below, master_clear_n, watchdog_expire, osc_tick;
    logic        core_sleeping, irq_wake, global_irq_enable;
    logic [12:0] core_pc, pc_load;
    logic        core_reset, core_wake;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0]  s_wstrb;
    logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    int          failures;
    int          samples_checked;
    int          n;

    rcseq_partner u_rcseq_partner (.aclk(aclk), .req(req), .supply_good(supply_good),
        .brownout_below(brownout_below), .master_clear_n(master_clear_n),
        .watchdog_expire(watchdog_expire), .osc_tick(osc_tick));

    rcseq_top #(.POWERUP_CYC(PWR_CYC)) u_rcseq_top (.aclk(aclk), .aresetn(aresetn),
        .supply_good(supply_good), .brownout_below(brownout_below),
        .master_clear_n(master_clear_n), .watchdog_expire(watchdog_expire),
        .osc_tick(osc_tick), .core_sleeping(core_sleeping), .irq_wake(irq_wake),
        .global_irq_enable(global_irq_enable), .core_pc(core_pc), .core_reset(core_reset),
        .core_wake(core_wake), .pc_load(pc_load), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_wstrb   <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && k < 100);
        s_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_bresp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && k < 100);
        s_rready <= 1'b0;
        chk("rdata", ed, s_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_rresp});
    endtask

    // wait for core_reset to reach v within lim cycles
    task automatic wait_rst(input logic v, input int lim);
        int k;
        k = 0;
        while (core_reset !== v && k < lim) begin
            @(posedge aclk);
            k++;
        end
        chk("core_reset", {31'h0, v}, {31'h0, core_reset});
    endtask

    // hold request pattern m for c cycles, then release
    task automatic hold(input logic [3:0] m, input int c);
        @(posedge aclk);
        req <= m;
        repeat (c) @(posedge aclk);
        req <= 4'h0;
    endtask

    task automatic results;
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial begin
        repeat (100000) @(posedge aclk);
        failures++;
        results();
    end

    initial begin
        {aresetn, irq_wake, global_irq_enable, core_sleeping} = 4'h0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        {s_awaddr, s_araddr, s_wstrb, core_pc} = 41'h000_0000_0000;
        s_wdata = 32'h0000_0000;
        req = 4'h2;
        failures = 0;
        samples_checked = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CORE_STATUS, 32'h0000_0018, RESP_OKAY);
        rd(ADDR_RESET_CAUSE, 32'h0000_0000, RESP_OKAY);
        rd(ADDR_CONFIG, 32'h0000_0001, RESP_OKAY);
        rd(12'h010, 32'h0000_0000, RESP_SLVERR);
        wr(ADDR_PC, 32'h0000_0001, RESP_SLVERR);
        repeat (5000) @(posedge aclk);
        chk("held by pin", 32'h0000_0001, {31'h0, core_reset});
        req <= 4'h0;
        wait_rst(1'b0, 80);
        wr(ADDR_RESET_CAUSE, 32'h0000_0003, RESP_OKAY);
        wr(ADDR_CORE_STATUS, 32'h0000_0005, RESP_OKAY);
        rd(ADDR_CORE_STATUS, 32'h0000_001d, RESP_OKAY);
        // watchdog expiry while running
        hold(4'h1, 4);
        wait_rst(1'b1, 30);
        wait_rst(1'b0, 5000);
        rd(ADDR_CORE_STATUS, 32'h0000_000d, RESP_OKAY);
        rd(ADDR_RESET_CAUSE, 32'h0000_0003, RESP_OKAY);
        // short then long master-clear pulse
        hold(4'h2, 20);
        repeat (60) @(posedge aclk);
        chk("glitch", 32'h0000_0000, {31'h0, core_reset});
        hold(4'h2, 100);
        chk("pin reset", 32'h0000_0001, {31'h0, core_reset});
        wait_rst(1'b0, 5000);
        rd(ADDR_CORE_STATUS, 32'h0000_000d, RESP_OKAY);
        rd(ADDR_RESET_CAUSE, 32'h0000_0003, RESP_OKAY);
        // brown-out, external clock, delay enabled
        wr(ADDR_CONFIG, 32'h0000_0011, RESP_OKAY);
        hold(4'hc, 2100);
        chk("brown-out", 32'h0000_0001, {31'h0, core_reset});
        repeat (40) @(posedge aclk);
        chk("delay", 32'h0000_0001, {31'h0, core_reset});
        wait_rst(1'b0, 60);
        rd(ADDR_RESET_CAUSE, 32'h0000_0002, RESP_OKAY);
        rd(ADDR_CORE_STATUS, 32'h0000_001d, RESP_OKAY);
        // supply dip while the delay runs
        hold(4'hc, 2100);
        repeat (30) @(posedge aclk);
        hold(4'h8, 8);
        repeat (40) @(posedge aclk);
        chk("restart", 32'h0000_0001, {31'h0, core_reset});
        wait_rst(1'b0, 60);
        wr(ADDR_CONFIG, 32'h0000_0013, RESP_OKAY);
        hold(4'hc, 2100);
        wait_rst(1'b0, 25);
        // low-power crystal adds oscillator periods
        wr(ADDR_CONFIG, 32'h0000_0001, RESP_OKAY);
        hold(4'hc, 2100);
        repeat (1000) @(posedge aclk);
        chk("osc count", 32'h0000_0001, {31'h0, core_reset});
        wait_rst(1'b0, 5000);
        wr(ADDR_CONFIG, 32'h0000_0010, RESP_OKAY);
        hold(4'h4, 2100);
        chk("detect off", 32'h0000_0000, {31'h0, core_reset});
        wr(ADDR_CONFIG, 32'h0000_0011, RESP_OKAY);
        hold(4'h4, 1000);
        chk("short dip", 32'h0000_0000, {31'h0, core_reset});
        // watchdog wake from sleep
        core_sleeping <= 1'b1;
        core_pc <= 13'h0123;
        hold(4'h1, 4);
        n = 0;
        while (core_wake !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        chk("pc_load", 32'h0000_0124, {19'h0, pc_load});
        chk("no reset", 32'h0000_0000, {31'h0, core_reset});
        rd(ADDR_CORE_STATUS, 32'h0000_0005, RESP_OKAY);
        rd(ADDR_RESET_CAUSE, 32'h0000_0002, RESP_OKAY);
        // interrupt wake with global enable set
        global_irq_enable <= 1'b1;
        @(posedge aclk);
        irq_wake <= 1'b1;
        @(posedge aclk);
        irq_wake <= 1'b0;
        n = 0;
        while (core_wake !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        chk("irq pc_load", 32'h0000_0004, {19'h0, pc_load});
        rd(ADDR_CORE_STATUS, 32'h0000_0015, RESP_OKAY);
        // master clear during sleep
        hold(4'h2, 100);
        core_sleeping <= 1'b0;
        wait_rst(1'b0, 200);
        rd(ADDR_CORE_STATUS, 32'h0000_0015, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_RESET_CAUSE, 32'h0000_0000, RESP_OKAY);
        results();
    end
endmodule
